// >>> hw/dsg_gate_bank.sv
// deep-sleep clock gate bank with run, sleep and deep sets and an AXI4-Lite slave
//
// How it works
// RL1: each gate bit clocks or stops one unit
// RL2: access to an unclocked unit gets a fault
// RL3: reset clears every gate bit to zero
// RL4: software enables every unit it needs
// RL5: run, sleep, deep sets follow power state
// RL6: sleep sets apply only with auto gating
// RL7: bits 19..16 gate counters 3..0
// RL8: bit 14 gates two-wire port b
// RL9: bit 12 gates two-wire port a
// RL10: bit 4 gates synchronous serial port
// RL11: bits 2..0 gate async serial c..a
// RL12: other bits read zero, writes ignored
`timescale 1ns/1ns

module dsg_gate_bank
  import dsg_pkg::*;
#(
  parameter int ADDR_W = 12                   // byte address width
) (
  input  wire logic              core_clk,      // system clock, 100 MHz
  input  wire logic              sys_rst,       // async reset, active high
  // write address channel
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,  // write byte address
  input  wire logic              s_axi_awvalid, // write address valid
  output logic                   s_axi_awready, // write address ready
  // write data channel
  input  wire logic [31:0]       s_axi_wdata,   // write data
  input  wire logic [3:0]        s_axi_wstrb,   // byte enables
  input  wire logic              s_axi_wvalid,  // write data valid
  output logic                   s_axi_wready,  // write data ready
  // write response channel
  output logic [1:0]             s_axi_bresp,   // write response
  output logic                   s_axi_bvalid,  // write response valid
  input  wire logic              s_axi_bready,  // write response ready
  // read address channel
  input  wire logic [ADDR_W-1:0] s_axi_araddr,  // read byte address
  input  wire logic              s_axi_arvalid, // read address valid
  output logic                   s_axi_arready, // read address ready
  // read data channel
  output logic [31:0]            s_axi_rdata,   // read data
  output logic [1:0]             s_axi_rresp,   // read response
  output logic                   s_axi_rvalid,  // read data valid
  input  wire logic              s_axi_rready,  // read data ready
  // power state from the system controller
  input  wire logic              sleep_in,      // core is in sleep
  input  wire logic              deep_sleep_in, // core is in deep-sleep
  // peripheral access check
  input  wire logic              periph_req,    // unit access attempted
  input  wire logic [3:0]        periph_unit,   // unit index 0..9
  output logic                   periph_ok,     // access allowed, pulse
  output logic                   periph_fault,  // bus fault, pulse
  // gated clock enables and interrupt
  output logic [31:0]            gate_en,       // live clock enables
  output logic                   irq            // level interrupt
);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------

  // byte-lane merge that keeps read-only bits at zero
  function automatic logic [31:0] merge_wr(
    input logic [31:0] old_val,
    input logic [31:0] new_val,
    input logic [3:0]  strb,
    input logic [31:0] wmask
  );
    logic [31:0] lanes;
    lanes = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
    merge_wr = ((old_val & ~lanes) | (new_val & lanes)) & wmask;
  endfunction

  // unit index to gate bit position
  function automatic int unit_bit(input logic [3:0] idx);
    case (idx)
      4'h0:    unit_bit = DSG_BIT_ASYNC_A;
      4'h1:    unit_bit = DSG_BIT_ASYNC_B;
      4'h2:    unit_bit = DSG_BIT_ASYNC_C;
      4'h3:    unit_bit = DSG_BIT_SYNC;
      4'h4:    unit_bit = DSG_BIT_TWOW_A;
      4'h5:    unit_bit = DSG_BIT_TWOW_B;
      4'h6:    unit_bit = DSG_BIT_GP_CNT_0;
      4'h7:    unit_bit = DSG_BIT_GP_CNT_1;
      4'h8:    unit_bit = DSG_BIT_GP_CNT_2;
      default: unit_bit = DSG_BIT_GP_CNT_3;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  logic [ADDR_W-1:0] aw_addr_reg;
  logic              aw_full_reg;
  logic [31:0]       w_data_reg;
  logic [3:0]        w_strb_reg;
  logic              w_full_reg;
  logic              awready_reg;
  logic              wready_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              arready_reg;
  logic              rvalid_reg;
  logic [31:0]       rdata_reg;
  logic [1:0]        rresp_reg;
  logic [31:0]       run_cfg_reg;
  logic [31:0]       run_gate_reg;
  logic [31:0]       sleep_gate_reg;
  logic [31:0]       deep_gate_reg;
  logic [31:0]       irq_stat_reg;
  logic [31:0]       irq_mask_reg;
  logic [31:0]       gate_en_reg;
  logic              irq_reg;
  logic              periph_ok_reg;
  logic              periph_fault_reg;
  dsg_pwr_t          pwr_reg;
  dsg_pwr_t          pwr_next;

  // ----------------------------------------------------------------------
  // write path decode
  // ----------------------------------------------------------------------
  wire logic        aw_fire   = s_axi_awvalid & awready_reg;
  wire logic        w_fire    = s_axi_wvalid & wready_reg;
  // commit once both halves are held and the last answer has gone
  wire logic        wr_commit = aw_full_reg & w_full_reg & ~bvalid_reg;
  wire logic [11:0] wr_off    = 12'(aw_addr_reg & ~ADDR_W'(3));
  wire logic        wr_cfg    = wr_commit & (wr_off == DSG_OFF_RUN_CFG);
  wire logic        wr_run    = wr_commit & (wr_off == DSG_OFF_RUN_GATE);
  wire logic        wr_sleep  = wr_commit & (wr_off == DSG_OFF_SLEEP_GATE);
  wire logic        wr_deep   = wr_commit & (wr_off == DSG_OFF_DEEP_GATE);
  wire logic        wr_mask   = wr_commit & (wr_off == DSG_OFF_IRQ_MASK);
  // status is read-to-clear, so a write there only acknowledges
  wire logic        wr_stat   = wr_commit & (wr_off == DSG_OFF_IRQ_STAT);
  wire logic        wr_hit    = wr_cfg | wr_run | wr_sleep | wr_deep |
                                wr_mask | wr_stat;
  wire logic        aw_full_next = (aw_full_reg | aw_fire) & ~wr_commit;
  wire logic        w_full_next  = (w_full_reg | w_fire) & ~wr_commit;
  wire logic        bvalid_next  = wr_commit |
                                   (bvalid_reg & ~s_axi_bready);

  // ----------------------------------------------------------------------
  // read path decode
  // ----------------------------------------------------------------------
  wire logic        ar_fire     = s_axi_arvalid & arready_reg;
  wire logic        rvalid_next = ar_fire | (rvalid_reg & ~s_axi_rready);
  wire logic [11:0] rd_off      = 12'(s_axi_araddr & ~ADDR_W'(3));
  wire logic        rd_cfg      = rd_off == DSG_OFF_RUN_CFG;
  wire logic        rd_run      = rd_off == DSG_OFF_RUN_GATE;
  wire logic        rd_sleep    = rd_off == DSG_OFF_SLEEP_GATE;
  wire logic        rd_deep     = rd_off == DSG_OFF_DEEP_GATE;
  wire logic        rd_stat     = rd_off == DSG_OFF_IRQ_STAT;
  wire logic        rd_mask     = rd_off == DSG_OFF_IRQ_MASK;
  wire logic        rd_hit      = rd_cfg | rd_run | rd_sleep | rd_deep |
                                  rd_stat | rd_mask;
  wire logic [31:0] rd_word     =
    ({32{rd_cfg}}   & run_cfg_reg)    |
    ({32{rd_run}}   & run_gate_reg)   |
    ({32{rd_sleep}} & sleep_gate_reg) |
    ({32{rd_deep}}  & deep_gate_reg)  |   // see RL12
    ({32{rd_stat}}  & irq_stat_reg)   |
    ({32{rd_mask}}  & irq_mask_reg);
  wire logic        stat_clr    = ar_fire & rd_stat;

  // ----------------------------------------------------------------------
  // power state and gate selection
  // ----------------------------------------------------------------------

  // deep-sleep wins if the controller flags both
  always_comb begin
    if (deep_sleep_in) begin
      pwr_next = DSG_PWR_DEEP;
    end else if (sleep_in) begin
      pwr_next = DSG_PWR_SLEEP;
    end else begin
      pwr_next = DSG_PWR_RUN;
    end
  end

  wire logic auto_gating_select = run_cfg_reg[DSG_BIT_AUTO_GATING];

  // without auto gating the run set stays in force in every state
  logic [31:0] gate_sel;
  always_comb begin
    gate_sel = run_gate_reg;                            // see RL5
    if (auto_gating_select) begin                       // see RL6
      case (pwr_reg)
        DSG_PWR_SLEEP: gate_sel = sleep_gate_reg;
        DSG_PWR_DEEP:  gate_sel = deep_gate_reg;        // see RL5
        default:       gate_sel = run_gate_reg;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // peripheral access check and events
  // ----------------------------------------------------------------------
  // indices past the last unit name no clock, so they always fault
  wire logic        unit_valid = periph_unit < 4'(DSG_NUM_UNITS);
  wire logic        unit_on    = unit_valid &
                                 gate_en_reg[unit_bit(periph_unit)];
  wire logic        acc_ok     = periph_req & unit_on;  // see RL1
  wire logic        acc_fault  = periph_req & ~unit_on; // see RL2
  // a power-state change is logged so software can see each wake-up
  wire logic [31:0] events     =
    (32'(acc_fault) << DSG_EVT_FAULT) |
    (32'(pwr_next != pwr_reg) << DSG_EVT_PWR_CHANGE);
  // an event in the clearing read's cycle survives the clear
  wire logic [31:0] stat_next  =
    ((irq_stat_reg & ~{32{stat_clr}}) | events) & DSG_IRQ_MASK_BITS;

  // ----------------------------------------------------------------------
  // bus handshake registers
  // ----------------------------------------------------------------------

  // ready flags start low and rise one edge after reset
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_full_reg  <= 1'b0;
      w_full_reg   <= 1'b0;
      awready_reg  <= 1'b0;
      wready_reg   <= 1'b0;
      bvalid_reg   <= 1'b0;
      arready_reg  <= 1'b0;
      rvalid_reg   <= 1'b0;
    end else begin
      aw_full_reg  <= aw_full_next;
      w_full_reg   <= w_full_next;
      awready_reg  <= ~aw_full_next;
      wready_reg   <= ~w_full_next;
      bvalid_reg   <= bvalid_next;
      arready_reg  <= ~rvalid_next;
      rvalid_reg   <= rvalid_next;
    end
  end

  // captured payloads and answers
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      aw_addr_reg <= '0;
      w_data_reg  <= 32'h00000000;
      w_strb_reg  <= 4'h0;
      bresp_reg   <= DSG_RESP_OKAY;
      rdata_reg   <= 32'h00000000;
      rresp_reg   <= DSG_RESP_OKAY;
    end else begin
      if (aw_fire) begin
        aw_addr_reg <= s_axi_awaddr;
      end
      if (w_fire) begin
        w_data_reg <= s_axi_wdata;
        w_strb_reg <= s_axi_wstrb;
      end
      if (wr_commit) begin
        bresp_reg <= wr_hit ? DSG_RESP_OKAY : DSG_RESP_SLVERR;
      end
      if (ar_fire) begin
        rdata_reg <= rd_word;
        rresp_reg <= rd_hit ? DSG_RESP_OKAY : DSG_RESP_SLVERR;
      end
    end
  end

  // ----------------------------------------------------------------------
  // software registers
  // ----------------------------------------------------------------------

  // every gate set clears so no unit runs until software asks
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      run_cfg_reg    <= DSG_CFG_RESET;
      run_gate_reg   <= DSG_GATE_RESET;
      sleep_gate_reg <= DSG_GATE_RESET;
      deep_gate_reg  <= DSG_GATE_RESET;                 // see RL3
      irq_mask_reg   <= DSG_IRQ_RESET;
      irq_stat_reg   <= DSG_IRQ_RESET;
    end else begin
      if (wr_cfg) begin
        run_cfg_reg <= merge_wr(run_cfg_reg, w_data_reg, w_strb_reg,
                                DSG_CFG_MASK);
      end
      if (wr_run) begin
        run_gate_reg <= merge_wr(run_gate_reg, w_data_reg, w_strb_reg,
                                 DSG_GATE_MASK);
      end
      if (wr_sleep) begin
        sleep_gate_reg <= merge_wr(sleep_gate_reg, w_data_reg,
                                   w_strb_reg, DSG_GATE_MASK);
      end
      // mask keeps bits 19..16, 14, 12, 4, 2..0 writable
      if (wr_deep) begin
        deep_gate_reg <= merge_wr(deep_gate_reg, w_data_reg,
                                  w_strb_reg, DSG_GATE_MASK); // see RL7
      end                                     // see RL8 RL9 RL10 RL11
      if (wr_mask) begin
        irq_mask_reg <= merge_wr(irq_mask_reg, w_data_reg, w_strb_reg,
                                 DSG_IRQ_MASK_BITS);
      end
      irq_stat_reg <= stat_next;
    end
  end

  // ----------------------------------------------------------------------
  // power state, clock enables, access answers, interrupt
  // ----------------------------------------------------------------------

  // enables switch two edges after the power-state inputs change, one edge after a set changes
  always_ff @(posedge core_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_reg          <= DSG_PWR_RUN;
      gate_en_reg      <= DSG_GATE_RESET;
      periph_ok_reg    <= 1'b0;
      periph_fault_reg <= 1'b0;
      irq_reg          <= 1'b0;
    end else begin
      pwr_reg          <= pwr_next;
      gate_en_reg      <= gate_sel & DSG_GATE_MASK;     // see RL1
      periph_ok_reg    <= acc_ok;
      periph_fault_reg <= acc_fault;                    // see RL2
      irq_reg          <= |(stat_next & irq_mask_reg);
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign s_axi_awready = awready_reg;
  assign s_axi_wready  = wready_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;
  assign s_axi_arready = arready_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;
  assign gate_en       = gate_en_reg;
  assign periph_ok     = periph_ok_reg;
  assign periph_fault  = periph_fault_reg;
  assign irq           = irq_reg;

endmodule

// >>> hw/dsg_pkg.sv
// constants and types shared by the deep-sleep clock gate bank
package dsg_pkg;

  // ----------------------------------------------------------------------
  // register byte offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] DSG_OFF_RUN_CFG    = 12'h060;
  localparam logic [11:0] DSG_OFF_RUN_GATE   = 12'h104;
  localparam logic [11:0] DSG_OFF_SLEEP_GATE = 12'h114;
  localparam logic [11:0] DSG_OFF_DEEP_GATE  = 12'h124;
  localparam logic [11:0] DSG_OFF_IRQ_STAT   = 12'h140;
  localparam logic [11:0] DSG_OFF_IRQ_MASK   = 12'h144;

  // ----------------------------------------------------------------------
  // gate register fields
  // ----------------------------------------------------------------------
  localparam int DSG_BIT_ASYNC_A  = 0;
  localparam int DSG_BIT_ASYNC_B  = 1;
  localparam int DSG_BIT_ASYNC_C  = 2;
  localparam int DSG_BIT_SYNC     = 4;
  localparam int DSG_BIT_TWOW_A   = 12;
  localparam int DSG_BIT_TWOW_B   = 14;
  localparam int DSG_BIT_GP_CNT_0 = 16;
  localparam int DSG_BIT_GP_CNT_1 = 17;
  localparam int DSG_BIT_GP_CNT_2 = 18;
  localparam int DSG_BIT_GP_CNT_3 = 19;
  localparam logic [31:0] DSG_GATE_MASK  = 32'h000F5017;
  localparam logic [31:0] DSG_GATE_RESET = 32'h00000000;
  localparam int          DSG_NUM_UNITS  = 10;

  // ----------------------------------------------------------------------
  // run configuration, interrupt status and mask fields
  // ----------------------------------------------------------------------
  localparam int          DSG_BIT_AUTO_GATING = 0;
  localparam logic [31:0] DSG_CFG_MASK        = 32'h00000001;
  localparam logic [31:0] DSG_CFG_RESET       = 32'h00000000;
  localparam int          DSG_EVT_FAULT       = 0;
  localparam int          DSG_EVT_PWR_CHANGE  = 1;
  localparam logic [31:0] DSG_IRQ_MASK_BITS   = 32'h00000003;
  localparam logic [31:0] DSG_IRQ_RESET       = 32'h00000000;

  // ----------------------------------------------------------------------
  // bus answers and power states
  // ----------------------------------------------------------------------
  localparam logic [1:0] DSG_RESP_OKAY   = 2'h0;
  localparam logic [1:0] DSG_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DSG_PWR_RUN,
    DSG_PWR_SLEEP,
    DSG_PWR_DEEP
  } dsg_pwr_t;

endpackage

// >>> tb/dsg_gate_bank_chk.sv
// assertion checker for the deep-sleep clock gate bank
`timescale 1ns/1ns
module dsg_gate_bank_chk
  import dsg_pkg::*;
(
  input wire logic        core_clk,      // system clock
  input wire logic        sys_rst,       // async reset
  input wire logic        s_axi_awvalid, // aw valid
  input wire logic        s_axi_awready, // aw ready
  input wire logic        s_axi_wvalid,  // w valid
  input wire logic        s_axi_wready,  // w ready
  input wire logic [1:0]  s_axi_bresp,   // write response
  input wire logic        s_axi_bvalid,  // b valid
  input wire logic        s_axi_bready,  // b ready
  input wire logic        s_axi_arvalid, // ar valid
  input wire logic        s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata,   // read data
  input wire logic        s_axi_rvalid,  // r valid
  input wire logic        s_axi_rready,  // r ready
  input wire logic        periph_req,    // access attempt
  input wire logic [3:0]  periph_unit,   // unit index
  input wire logic        periph_ok,     // access allowed
  input wire logic        periph_fault,  // bus fault
  input wire logic [31:0] gate_en        // live enables
);
  // ----------------------------------------------------------------------
  // unit decode
  // ----------------------------------------------------------------------
  localparam int UB [10] = '{0, 1, 2, 4, 12, 14, 16, 17, 18, 19};
  wire logic unit_valid;
  wire logic unit_on;
  // out-of-range indices never count as clocked
  assign unit_valid = periph_unit < 4'hA;
  assign unit_on    = unit_valid ? gate_en[UB[periph_unit]] : 1'b0;

  default clocking @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  sequence s_wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_take;
    s_axi_arvalid && s_axi_arready;
  endsequence

  // ----------------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------------
  chk_access_ok: assert property (periph_req && unit_on |=>
    periph_ok && !periph_fault) else $error("allowed access not granted");
  chk_access_fault: assert property (periph_req && !unit_on |=>
    periph_fault && !periph_ok) else $error("gated access not faulted");
  chk_no_stray: assert property (!periph_req |=>
    !periph_ok && !periph_fault) else $error("answer without request");
  chk_reserved_zero: assert property (
    (gate_en & ~DSG_GATE_MASK) == 32'h00000000) else $error("reserved set");
  // looked at one edge on: before the first edge the flops are unknown
  chk_reset_clear: assert property (disable iff (1'b0)
    sys_rst |=> gate_en == 32'h00000000) else $error("enables in reset");
  chk_wr_answer: assert property (s_wr_both |-> ##[1:2] s_axi_bvalid)
    else $error("write not answered");
  chk_rd_answer: assert property (s_rd_take |=> s_axi_rvalid)
    else $error("read not answered");
  chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("b not held");
  chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("r not held");
endmodule

bind dsg_gate_bank dsg_gate_bank_chk u_chk (
  .core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid),
  .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid),
  .s_axi_rready(s_axi_rready), .periph_req(periph_req),
  .periph_unit(periph_unit), .periph_ok(periph_ok),
  .periph_fault(periph_fault), .gate_en(gate_en));

// >>> tb/deep_sleep_clock_gate_bank_tb_top.sv
// self-checking bench for the deep-sleep clock gate bank
`timescale 1ns/1ns
module deep_sleep_clock_gate_bank_tb_top
  import dsg_pkg::*;
;
  logic core_clk = 0, sys_rst = 1;
  logic [11:0] awaddr = 0, araddr = 0;
  logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [31:0] wdata = 0, rdata, gate_en;
  logic [3:0] wstrb = 4'hF, punit = 0, s;
  logic sleep_in = 0, deep_in = 0, preq = 0;
  logic awready, wready, bvalid, arready, rvalid, pok, pflt, irq;
  logic [1:0] bresp, rresp, r;
  logic [31:0] v, d, gv [3];
  logic ok, flt, e;
  int num_errors = 0, checks_done = 0, cyc = 0;
  localparam int UB [10] = '{0, 1, 2, 4, 12, 14, 16, 17, 18, 19};
  localparam logic [11:0] GO [3] = '{DSG_OFF_RUN_GATE, DSG_OFF_SLEEP_GATE,
                                     DSG_OFF_DEEP_GATE};
  localparam logic [2:0] PW [4] = '{3'h1, 3'h7, 3'h6, 3'h4};

  dsg_gate_bank u_dut (
    .core_clk(core_clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .sleep_in(sleep_in), .deep_sleep_in(deep_in),
    .periph_req(preq), .periph_unit(punit), .periph_ok(pok),
    .periph_fault(pflt), .gate_en(gate_en), .irq(irq));

  // ----------------------------------------------------------------------
  // clock, timeout and shared tasks
  // ----------------------------------------------------------------------
  always #5 core_clk = ~core_clk;
  // whole run needs well under a thousand cycles
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      num_errors = num_errors + 1;
      end_of_test();
    end
  end

  task automatic end_of_test();
    $display("errors %0d checks %0d", num_errors, checks_done);
    if (num_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // expected register after a strobed write, reserved bits held at zero
  function automatic logic [31:0] lane_merge(input logic [31:0] o,
                                             input logic [31:0] n,
                                             input logic [3:0] sb);
    logic [31:0] ln;
    ln = {{8{sb[3]}}, {8{sb[2]}}, {8{sb[1]}}, {8{sb[0]}}};
    return ((o & ~ln) | (n & ln)) & DSG_GATE_MASK;
  endfunction

  // write: address and data offered together, each dropped when taken;
  // lag delays bready so the answer has to wait
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] dv,
                        input int lag = 0);
    @(posedge core_clk);
    awaddr <= a; awvalid <= 1; wdata <= dv; wvalid <= 1;
    bready <= (lag == 0);
    do begin
      @(posedge core_clk);
      if (awvalid && awready) awvalid <= 0;
      if (wvalid && wready) wvalid <= 0;
      if (lag == 1) bready <= 1;
      lag--;
    end while (!(bvalid && bready));
    r = bresp;
    bready <= 0;
  endtask

  task automatic axi_rd(input logic [11:0] a, input int lag = 0);
    @(posedge core_clk);
    araddr <= a; arvalid <= 1;
    rready <= (lag == 0);
    do begin
      @(posedge core_clk);
      if (arvalid && arready) arvalid <= 0;
      if (lag == 1) rready <= 1;
      lag--;
    end while (!(rvalid && rready));
    d = rdata; r = rresp;
    rready <= 0;
  endtask

  // one access attempt, answer sampled the cycle it stands
  task automatic poke(input logic [3:0] u);
    @(posedge core_clk);
    preq <= 1; punit <= u;
    @(posedge core_clk);
    preq <= 0;
    @(posedge core_clk);
    ok = pok; flt = pflt;
  endtask

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial begin
    void'($urandom(32'h4A937DE4));
    repeat (5) @(posedge core_clk);
    sys_rst <= 0;
    for (int i = 0; i < 3; i++) begin
      axi_rd(GO[i]);
      chk(d, 32'h00000000);
    end
    chk(gate_en, 32'h00000000);
    poke(4'h0);
    chk({ok, flt}, 2'h1);
    chk(irq, 1'b0);
    // software enables what it needs, reserved bits tried too
    for (int k = 0; k < 4; k++) begin
      for (int i = 0; i < 3; i++) begin
        v = (k == 0) ? 32'hFFFFFFFF : $urandom;
        s = (k == 0) ? 4'hF : 4'($urandom);
        wstrb <= s;
        gv[i] = lane_merge(gv[i], v, s);
        // later rounds raise ready late so the answer must stand
        axi_wr(GO[i], v, k);
        chk(r, DSG_RESP_OKAY);
        axi_rd(GO[i], k);
        chk(d, gv[i]);
        chk(r, DSG_RESP_OKAY);
      end
    end
    wstrb <= 4'hF;
    // power states with and without auto gating
    for (int k = 0; k < 4; k++) begin
      axi_wr(DSG_OFF_RUN_CFG, {31'h0, PW[k][2]});
      sleep_in <= PW[k][1];
      deep_in <= PW[k][0];
      repeat (4) @(posedge core_clk);
      v = !PW[k][2] ? gv[0] : PW[k][0] ? gv[2] : PW[k][1] ? gv[1] : gv[0];
      chk(gate_en, v);
    end
    // every unit index, invalid ones included
    for (int u = 0; u < 16; u++) begin
      poke(u[3:0]);
      e = (u < 10) ? gv[0][UB[u]] : 1'b0;
      chk({ok, flt}, {e, !e});
    end
    axi_rd(12'h200);
    chk(r, DSG_RESP_SLVERR);
    chk(d, 32'h00000000);
    axi_wr(12'h200, 32'hFFFFFFFF);
    chk(r, DSG_RESP_SLVERR);
    // fault event raised earlier shows once unmasked, read clears it
    axi_wr(DSG_OFF_IRQ_MASK, 32'h00000001);
    repeat (3) @(posedge core_clk);
    chk(irq, 1'b1);
    axi_rd(DSG_OFF_IRQ_STAT);
    chk(d[0], 1'b1);
    chk(d[1], 1'b1);
    repeat (3) @(posedge core_clk);
    chk(irq, 1'b0);
    axi_rd(DSG_OFF_IRQ_STAT);
    chk(d, 32'h00000000);
    // second reset in mid-run must drop every set and enable again
    sys_rst <= 1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 0;
    for (int i = 0; i < 3; i++) begin
      axi_rd(GO[i]);
      chk(d, 32'h00000000);
    end
    chk(gate_en, 32'h00000000);
    end_of_test();
  end
endmodule
